// ==== rtl/acsr_pkg.sv ====
package acsr_pkg;
   localparam int AXES = 2;
   localparam int CLK_MHZ = 250;

   // Register offsets.
   localparam logic [7:0] OFS_ARM_CONFIG_X = 8'h0E;
   localparam logic [7:0] OFS_ARM_CONFIG_Y = 8'h0F;
   localparam logic [7:0] OFS_ARM_THRESHOLD_X_POS = 8'h10;
   localparam logic [7:0] OFS_ARM_THRESHOLD_Y_POS = 8'h11;
   localparam logic [7:0] OFS_ARM_THRESHOLD_X_NEG = 8'h12;
   localparam logic [7:0] OFS_ARM_THRESHOLD_Y_NEG = 8'h13;
   localparam logic [7:0] OFS_DEVICE_STATUS_FLAGS = 8'h14;

   // Reset values.
   localparam logic [7:0] ARM_CONFIG_RST = 8'h0F;
   localparam logic [7:0] ARM_THRESHOLD_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h01;

   // Arming configuration fields.
   localparam int CFG_WIN_POS_LSB = 0;
   localparam int CFG_WIN_NEG_LSB = 2;
   localparam int CFG_STRETCH_LSB = 4;

   // Status bit positions.
   localparam int ST_RESET_OCCURRED = 0;
   localparam int ST_OFFSET_X = 1;
   localparam int ST_OFFSET_Y = 2;
   localparam int ST_SERIAL_OUT_MISMATCH = 3;
   localparam int ST_INIT_IN_PROGRESS = 4;
   localparam int ST_MODULATOR_OVERRANGE = 5;
   localparam int ST_INTERNAL_DATA_ERROR = 6;
   localparam logic [7:0] STATUS_CLEAR_MASK = 8'h6F;

   // Pulse stretch times in microseconds and their cycle counts.
   localparam int STRETCH1_US = 16384;
   localparam int STRETCH2_US = 65536;
   localparam int STRETCH3_US = 262016;
   localparam int STRETCH1_CYC = STRETCH1_US * CLK_MHZ;
   localparam int STRETCH2_CYC = STRETCH2_US * CLK_MHZ;
   localparam int STRETCH3_CYC = STRETCH3_US * CLK_MHZ;

   // Integrity check polynomial x^3 + x + 1 and seed.
   localparam logic [2:0] CRC_POLY = 3'h3;
   localparam logic [2:0] CRC_SEED = 3'h7;

   typedef enum logic [2:0] {
      ACSR_MODE_OFF = 3'h0,
      ACSR_MODE_PCM = 3'h1,
      ACSR_MODE_MA_HI = 3'h2,
      ACSR_MODE_MA_LO = 3'h3,
      ACSR_MODE_CNT_HI = 3'h4,
      ACSR_MODE_CNT_LO = 3'h5,
      ACSR_MODE_RAW_HI = 3'h6,
      ACSR_MODE_RAW_LO = 3'h7
   } acsr_mode_t;
endpackage

// ==== rtl/acsr_regs.sv ====
// Overview of operation
// - Stretch codes 00/01/10/11 extend arming output by 0, 16.384, 65.536, 262.016 ms.
// - Stretch intervals are timed by counting the device's own clock.
// - Window fields mean averaging length or count limit, chosen by axis mode.
// - Moving-average mode: each axis and polarity window selects 2, 4, 8 or 16 samples.
// - Count mode: limit 1, 3, 7 or 15 from positive field only.
// - Threshold writes accepted only before the init-done lock is set.
// - Threshold registers are covered by the writable register integrity check.
// - Each threshold is an independent unsigned 8-bit level, one output step each.
// - A zero threshold disables only that polarity; the other keeps arming.
// - Both thresholds zero disables the axis and its arming pin in any mode.
// - Status register is read-only; a read clears its transient flags.
// - Unused top status bit may read either value and affects nothing.
// - Internal data error flag, bit 6, set by integrity or internal faults; read clears.
// - Writable register integrity fault re-asserts the flag after reads until reset.
// - Fuse data fault re-asserts the flag even after reset.
// - Config fields are used only in moving-average or count mode, else ignored.
// - Config registers writable until init-done lock, then locked and integrity checked.
`timescale 1ns/1ps
`default_nettype none
module acsr_regs
   import acsr_pkg::*;
#(
   parameter int STRETCH_W = 27,
   parameter int STRETCH1 = STRETCH1_CYC,
   parameter int STRETCH2 = STRETCH2_CYC,
   parameter int STRETCH3 = STRETCH3_CYC
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   // Device configuration.
   input wire logic init_done_lock,
   input wire logic [AXES-1:0][2:0] arm_mode,
   // Status events.
   input wire logic ev_reset_occurred,
   input wire logic ev_offset_x,
   input wire logic ev_offset_y,
   input wire logic ev_serial_out_mismatch,
   input wire logic ev_modulator_overrange,
   input wire logic ev_internal_fault,
   input wire logic otp_crc_fault,
   input wire logic fuse_fault,
   input wire logic init_in_progress,
   // Arming datapath side.
   input wire logic [AXES-1:0] arm_trig,
   output logic [AXES-1:0][7:0] level_pos,
   output logic [AXES-1:0][7:0] level_neg,
   output logic [AXES-1:0] cmp_en_pos,
   output logic [AXES-1:0] cmp_en_neg,
   output logic [AXES-1:0][4:0] window_pos,
   output logic [AXES-1:0][4:0] window_neg,
   output logic [AXES-1:0][3:0] count_limit,
   output logic [AXES-1:0] arm_level,
   output logic [AXES-1:0] arm_pin,
   output logic [AXES-1:0] arm_pin_oe,
   output logic [2:0] wr_crc
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [4:0] ma_size(input logic [1:0] code);
      ma_size = 5'h02 << code;
   endfunction

   function automatic logic [3:0] cnt_size(input logic [1:0] code);
      cnt_size = 4'((5'h02 << code) - 5'h01);
   endfunction

   function automatic logic [STRETCH_W-1:0] stretch_len(input logic [1:0] code);
      case (code)
         2'h1: stretch_len = STRETCH_W'(STRETCH1);
         2'h2: stretch_len = STRETCH_W'(STRETCH2);
         2'h3: stretch_len = STRETCH_W'(STRETCH3);
         default: stretch_len = '0;
      endcase
   endfunction

   function automatic logic [2:0] crc3(input logic [47:0] d);
      logic [2:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 47; i >= 0; i--) begin
         fb = c[2] ^ d[i];
         c = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
      end
      crc3 = c;
   endfunction

   logic [7:0] arm_config_reg [AXES];
   logic [7:0] arm_threshold_pos_reg [AXES];
   logic [7:0] arm_threshold_neg_reg [AXES];
   logic [7:0] status_flag_reg;
   logic lock_seen_reg;
   logic [2:0] crc_ref_reg;
   logic wr_crc_bad_reg;
   logic wr_ok;
   logic rd_status;
   logic ide_src;
   logic [7:0] status_set;
   logic [7:0] status_view;

   // Writes to configuration and thresholds are blocked while the lock is set or clk_en is low.
   assign wr_ok = clk_en & reg_wr & ~init_done_lock;
   assign rd_status = clk_en & reg_rd & hit(reg_addr, OFS_DEVICE_STATUS_FLAGS);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int a = 0; a < AXES; a++) begin
            arm_config_reg[a] <= ARM_CONFIG_RST;
            arm_threshold_pos_reg[a] <= ARM_THRESHOLD_RST;
            arm_threshold_neg_reg[a] <= ARM_THRESHOLD_RST;
         end
      end else if (wr_ok) begin
         // Reserved config bits are stored as written; the host keeps them zero.
         if (hit(reg_addr, OFS_ARM_CONFIG_X)) arm_config_reg[0] <= reg_wdata;
         if (hit(reg_addr, OFS_ARM_CONFIG_Y)) arm_config_reg[1] <= reg_wdata;
         if (hit(reg_addr, OFS_ARM_THRESHOLD_X_POS)) arm_threshold_pos_reg[0] <= reg_wdata;
         if (hit(reg_addr, OFS_ARM_THRESHOLD_Y_POS)) arm_threshold_pos_reg[1] <= reg_wdata;
         if (hit(reg_addr, OFS_ARM_THRESHOLD_X_NEG)) arm_threshold_neg_reg[0] <= reg_wdata;
         if (hit(reg_addr, OFS_ARM_THRESHOLD_Y_NEG)) arm_threshold_neg_reg[1] <= reg_wdata;
      end
   end

   // The check covers both config and all four threshold registers.
   assign wr_crc = crc3({arm_config_reg[0], arm_config_reg[1], arm_threshold_pos_reg[0],
      arm_threshold_pos_reg[1], arm_threshold_neg_reg[0], arm_threshold_neg_reg[1]});

   // A reference is taken when the lock rises; any later drift is a sticky fault.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lock_seen_reg <= 1'b0;
         crc_ref_reg <= CRC_SEED;
         wr_crc_bad_reg <= 1'b0;
      end else if (clk_en) begin
         lock_seen_reg <= init_done_lock;
         if (init_done_lock & ~lock_seen_reg) crc_ref_reg <= wr_crc;
         if (lock_seen_reg & (wr_crc != crc_ref_reg)) wr_crc_bad_reg <= 1'b1;
      end
   end

   // Persistent sources keep feeding the error flag, so a read cannot hide them.
   assign ide_src = ev_internal_fault | otp_crc_fault | wr_crc_bad_reg | fuse_fault;

   always_comb begin
      status_set = 8'h00;
      status_set[ST_RESET_OCCURRED] = ev_reset_occurred;
      status_set[ST_OFFSET_X] = ev_offset_x;
      status_set[ST_OFFSET_Y] = ev_offset_y;
      status_set[ST_SERIAL_OUT_MISMATCH] = ev_serial_out_mismatch;
      status_set[ST_MODULATOR_OVERRANGE] = ev_modulator_overrange;
      status_set[ST_INTERNAL_DATA_ERROR] = ide_src;
   end

   // Set wins over the read clear so an event in the read cycle is kept.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status_flag_reg <= STATUS_RST;
      end else if (clk_en) begin
         status_flag_reg <= (status_flag_reg & ~(rd_status ? STATUS_CLEAR_MASK : 8'h00))
            | (status_set & STATUS_CLEAR_MASK);
      end
   end

   // The unused bit reads zero; init progress is a live level untouched by reads.
   always_comb begin
      status_view = status_flag_reg & STATUS_CLEAR_MASK;
      status_view[ST_INIT_IN_PROGRESS] = init_in_progress;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_rd_valid <= 1'b0;
      end else if (clk_en) begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               OFS_ARM_CONFIG_X: reg_rdata <= arm_config_reg[0];
               OFS_ARM_CONFIG_Y: reg_rdata <= arm_config_reg[1];
               OFS_ARM_THRESHOLD_X_POS: reg_rdata <= arm_threshold_pos_reg[0];
               OFS_ARM_THRESHOLD_Y_POS: reg_rdata <= arm_threshold_pos_reg[1];
               OFS_ARM_THRESHOLD_X_NEG: reg_rdata <= arm_threshold_neg_reg[0];
               OFS_ARM_THRESHOLD_Y_NEG: reg_rdata <= arm_threshold_neg_reg[1];
               OFS_DEVICE_STATUS_FLAGS: reg_rdata <= status_view;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   for (genvar a = 0; a < AXES; a++) begin : g_axis
      acsr_mode_t mode;
      logic ma_mode;
      logic cnt_mode;
      logic axis_on;
      logic [STRETCH_W-1:0] stretch_cnt_reg;
      logic level_next;

      assign mode = acsr_mode_t'(arm_mode[a]);
      assign ma_mode = (mode == ACSR_MODE_MA_HI) | (mode == ACSR_MODE_MA_LO);
      assign cnt_mode = (mode == ACSR_MODE_CNT_HI) | (mode == ACSR_MODE_CNT_LO);
      assign level_pos[a] = arm_threshold_pos_reg[a];
      assign level_neg[a] = arm_threshold_neg_reg[a];
      assign cmp_en_pos[a] = (arm_threshold_pos_reg[a] != 8'h00);
      assign cmp_en_neg[a] = (arm_threshold_neg_reg[a] != 8'h00);
      assign axis_on = (cmp_en_pos[a] | cmp_en_neg[a]) & (mode != ACSR_MODE_OFF);

      // Window fields mean different things per mode and nothing elsewhere.
      assign window_pos[a] = ma_mode ? ma_size(arm_config_reg[a][CFG_WIN_POS_LSB +: 2]) : 5'h00;
      assign window_neg[a] = ma_mode ? ma_size(arm_config_reg[a][CFG_WIN_NEG_LSB +: 2]) : 5'h00;
      assign count_limit[a] = cnt_mode ? cnt_size(arm_config_reg[a][CFG_WIN_POS_LSB +: 2]) : 4'h0;

      // The stretch is a plain cycle count, so clock tolerance carries straight through.
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            stretch_cnt_reg <= '0;
         end else if (clk_en) begin
            if (arm_trig[a] & axis_on & (ma_mode | cnt_mode)) begin
               stretch_cnt_reg <= stretch_len(arm_config_reg[a][CFG_STRETCH_LSB +: 2]);
            end else if (stretch_cnt_reg != '0) begin
               stretch_cnt_reg <= stretch_cnt_reg - 1'b1;
            end
         end
      end

      assign level_next = axis_on & (arm_trig[a] | (stretch_cnt_reg != '0));

      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            arm_level[a] <= 1'b0;
            arm_pin[a] <= 1'b0;
            arm_pin_oe[a] <= 1'b0;
         end else if (clk_en) begin
            arm_level[a] <= level_next;
            arm_pin[a] <= (arm_mode[a][0] & (mode != ACSR_MODE_PCM)) ? ~level_next : level_next;
            arm_pin_oe[a] <= axis_on;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence thr_write_locked;
      clk_en && reg_wr && init_done_lock && hit(reg_addr, OFS_ARM_THRESHOLD_X_POS);
   endsequence

   sequence cfg_write_locked;
      clk_en && reg_wr && init_done_lock && hit(reg_addr, OFS_ARM_CONFIG_Y);
   endsequence

   sequence status_read_quiet;
      rd_status && !ide_src ##1 clk_en && !ide_src;
   endsequence

   thr_lock_hold_a: assert property (thr_write_locked |=> $stable(arm_threshold_pos_reg[0]))
      else $error("threshold changed while locked");
   cfg_lock_hold_a: assert property (cfg_write_locked |=> $stable(arm_config_reg[1]))
      else $error("config changed while locked");
   ide_read_clear_a: assert property (status_read_quiet |-> !status_flag_reg[ST_INTERNAL_DATA_ERROR])
      else $error("error flag not cleared by read");
   crc_fault_stick_a: assert property (wr_crc_bad_reg && clk_en |=> status_flag_reg[ST_INTERNAL_DATA_ERROR] && wr_crc_bad_reg)
      else $error("integrity fault not held");
   fuse_fault_set_a: assert property (fuse_fault && clk_en |=> status_flag_reg[ST_INTERNAL_DATA_ERROR])
      else $error("fuse fault not flagged");
   status_ro_a: assert property (clk_en && reg_wr && hit(reg_addr, OFS_DEVICE_STATUS_FLAGS) && !reg_rd
      && status_set == 8'h00 |=> $stable(status_flag_reg))
      else $error("status changed by write");
   unused_zero_a: assert property (reg_rd_valid && $past(reg_addr) == OFS_DEVICE_STATUS_FLAGS |-> !reg_rdata[7])
      else $error("unused status bit set");
   axis_off_pin_a: assert property (clk_en && arm_threshold_pos_reg[0] == 8'h00 && arm_threshold_neg_reg[0] == 8'h00
      |=> !arm_pin_oe[0] && !arm_level[0])
      else $error("axis armed with zero thresholds");
   one_pol_off_a: assert property (arm_threshold_pos_reg[1] == 8'h00 && arm_threshold_neg_reg[1] != 8'h00
      |-> !cmp_en_pos[1] && cmp_en_neg[1])
      else $error("polarity enables wrong");
   ma_window_a: assert property (arm_mode[0] == ACSR_MODE_MA_HI && arm_config_reg[0][1:0] == 2'h3
      |-> window_pos[0] == 5'h10 && count_limit[0] == 4'h0)
      else $error("moving average window wrong");
   cnt_limit_a: assert property (arm_mode[1] == ACSR_MODE_CNT_LO && arm_config_reg[1][1:0] == 2'h2
      |-> count_limit[1] == 4'h7 && window_neg[1] == 5'h00)
      else $error("count limit wrong");
   stretch_hold_a: assert property (clk_en && arm_level[0] && !arm_trig[0] && g_axis[0].axis_on
      && g_axis[0].stretch_cnt_reg > 1 |=> !clk_en || arm_level[0])
      else $error("stretch ended early");
   stretch_none_a: assert property (clk_en && arm_config_reg[0][5:4] == 2'h0 && !arm_trig[0]
      ##1 clk_en && !arm_trig[0] |=> !clk_en || !arm_level[0])
      else $error("stretch with zero code");

endmodule
`default_nettype wire

// ==== dv/acsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module acsr_host
   import acsr_pkg::*;
(
   // Clock.
   input wire logic core_clk,
   // Register port.
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rd_valid
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'h0;
      reg_wdata = 8'h00;
      reg_rd = 1'h0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr <= 1'h1;
      // Reserved top bits of the arming configs always go out as zero.
      if (a == OFS_ARM_CONFIG_X || a == OFS_ARM_CONFIG_Y) begin
         reg_wdata <= d & 8'h3F;
      end else begin
         reg_wdata <= d;
      end
      @(posedge core_clk);
      reg_wr <= 1'h0;
      // Released data must not keep looking valid.
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      d = (reg_rd_valid === 1'h1) ? reg_rdata : 8'hxx;
   endtask
endmodule
`default_nettype wire

// ==== dv/acsr_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module acsr_regs_test;
   import acsr_pkg::*;
   localparam int ST[4] = '{0, 8, 16, 32};
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic clk_en = 1'h1;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic reg_rd_valid;
   logic init_done_lock = 1'h0;
   logic [AXES-1:0][2:0] arm_mode = '0;
   logic [5:0] ev = 6'h00;
   logic otp_crc_fault = 1'h0;
   logic fuse_fault = 1'h0;
   logic init_in_progress = 1'h0;
   logic [AXES-1:0] arm_trig = '0;
   logic [AXES-1:0][7:0] level_pos;
   logic [AXES-1:0][7:0] level_neg;
   logic [AXES-1:0] cmp_en_pos;
   logic [AXES-1:0] cmp_en_neg;
   logic [AXES-1:0][4:0] window_pos;
   logic [AXES-1:0][4:0] window_neg;
   logic [AXES-1:0][3:0] count_limit;
   logic [AXES-1:0] arm_level;
   logic [AXES-1:0] arm_pin;
   logic [AXES-1:0] arm_pin_oe;
   logic [2:0] wr_crc;
   int mismatches = 0;
   int comparisons = 0;
   logic [7:0] sh[6] = '{8'h0F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};

   always #2 core_clk = ~core_clk;

   acsr_host u_acsr_host(.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rd_valid);

   acsr_regs #(.STRETCH1(ST[1]), .STRETCH2(ST[2]), .STRETCH3(ST[3])) u_acsr_regs(
      .core_clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rd_valid,
      .init_done_lock, .arm_mode, .ev_reset_occurred(ev[0]), .ev_offset_x(ev[1]), .ev_offset_y(ev[2]),
      .ev_serial_out_mismatch(ev[3]), .ev_modulator_overrange(ev[4]), .ev_internal_fault(ev[5]),
      .otp_crc_fault, .fuse_fault, .init_in_progress, .arm_trig, .level_pos, .level_neg, .cmp_en_pos,
      .cmp_en_neg, .window_pos, .window_neg, .count_limit, .arm_level, .arm_pin, .arm_pin_oe, .wr_crc);

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Writes go through the host and are mirrored while the bank is still open.
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_acsr_host.wr(a, d);
      if (!init_done_lock && a >= 8'h0E && a <= 8'h13) begin
         sh[int'(a) - 14] = d;
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      u_acsr_host.rd(a, d);
      chk(d & m, e);
   endtask

   function automatic logic [2:0] crc_of();
      logic [2:0] c;
      c = 3'h7;
      for (int i = 0; i < 6; i++) begin
         for (int b = 7; b >= 0; b--) begin
            c = {c[1:0], 1'h0} ^ (((c[2] ^ sh[i][b]) == 1'h1) ? 3'h3 : 3'h0);
         end
      end
      return c;
   endfunction

   // Counts how long axis X stays armed after a one-cycle trip.
   task automatic stretch(input int code);
      int n;
      int p;
      n = 0;
      p = 0;
      w(OFS_ARM_CONFIG_X, 8'(code << 4) | 8'h0F);
      @(posedge core_clk);
      arm_trig[0] <= 1'h1;
      @(posedge core_clk);
      arm_trig[0] <= 1'h0;
      repeat (60) begin
         #1;
         if (arm_level[0] === 1'h1) n++;
         if (arm_pin[0] === 1'h1) p++;
         @(posedge core_clk);
      end
      chk(8'(n), 8'(ST[code] + 1));
      // Active-high mode, so the pin follows the stretched level exactly.
      chk(8'(p), 8'(ST[code] + 1));
   endtask

   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 1'h0;
      for (int a = 14; a < 20; a++) rchk(8'(a), 8'hFF, sh[a - 14]);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, STATUS_RST);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h00);
      w(OFS_DEVICE_STATUS_FLAGS, 8'h7F);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h00);
      rchk(8'h20, 8'hFF, 8'h00);
      for (int m = 0; m < 8; m++) begin
         for (int c = 0; c < 4; c++) begin
            @(posedge core_clk);
            arm_mode[1] <= 3'(m);
            w(OFS_ARM_CONFIG_Y, 8'(c | ((3 - c) << 2)));
            #1;
            chk(8'(window_pos[1]), (m == 2 || m == 3) ? 8'(2 << c) : 8'h00);
            chk(8'(window_neg[1]), (m == 2 || m == 3) ? 8'(2 << (3 - c)) : 8'h00);
            chk(8'(count_limit[1]), (m == 4 || m == 5) ? 8'((2 << c) - 1) : 8'h00);
         end
      end
      w(OFS_ARM_THRESHOLD_X_POS, 8'h40);
      @(posedge core_clk);
      arm_mode <= {3'h2, 3'h2};
      arm_trig[1] <= 1'h1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(level_pos[0], 8'h40);
      chk(8'({cmp_en_pos[0], cmp_en_neg[0], arm_pin_oe[0]}), 8'h05);
      chk(8'({arm_pin_oe[1], arm_level[1], arm_pin[1]}), 8'h00);
      arm_trig[1] <= 1'h0;
      for (int c = 0; c < 4; c++) stretch(c);
      // A frozen clock enable must swallow the write.
      @(posedge core_clk);
      clk_en <= 1'h0;
      u_acsr_host.wr(OFS_ARM_THRESHOLD_Y_POS, 8'h77);
      clk_en <= 1'h1;
      rchk(OFS_ARM_THRESHOLD_Y_POS, 8'hFF, 8'h00);
      w(OFS_ARM_THRESHOLD_Y_NEG, 8'h5A);
      #1;
      chk(level_neg[1], 8'h5A);
      chk(8'({cmp_en_pos[1], cmp_en_neg[1]}), 8'h01);
      chk(8'(wr_crc), 8'(crc_of()));
      @(posedge core_clk);
      init_done_lock <= 1'h1;
      w(OFS_ARM_THRESHOLD_X_POS, 8'h11);
      rchk(OFS_ARM_THRESHOLD_X_POS, 8'hFF, 8'h40);
      w(OFS_ARM_CONFIG_X, 8'h00);
      rchk(OFS_ARM_CONFIG_X, 8'hFF, sh[0]);
      w(OFS_ARM_CONFIG_Y, 8'h00);
      rchk(OFS_ARM_CONFIG_Y, 8'hFF, sh[1]);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h00);
      @(posedge core_clk);
      ev <= 6'h3F;
      init_in_progress <= 1'h1;
      @(posedge core_clk);
      ev <= 6'h00;
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h7F);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h10);
      @(posedge core_clk);
      init_in_progress <= 1'h0;
      otp_crc_fault <= 1'h1;
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h40);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h40);
      @(posedge core_clk);
      otp_crc_fault <= 1'h0;
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h40);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h00);
      @(posedge core_clk);
      fuse_fault <= 1'h1;
      reset <= 1'h1;
      repeat (2) @(posedge core_clk);
      reset <= 1'h0;
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h41);
      rchk(OFS_DEVICE_STATUS_FLAGS, 8'h7F, 8'h40);
      give_verdict();
   end
endmodule
`default_nettype wire
